// *** core/phd_pkg.sv ***
// package: sizes, register map, field layout and types of the peripheral hub
package phd_pkg;
  localparam int NCH       = 24;
  localparam int NTD       = 128;
  localparam int NSPK      = 8;
  localparam int NLVL      = 8;
  localparam int AW        = 32;
  localparam int DW        = 32;
  localparam int BURST_DEF = 4;

  // spoke routing: spoke number sits in the top address bits
  localparam int         SPK_LSB   = 29;
  localparam logic [2:0] SPK_SRAM  = 3'h0;
  localparam logic [2:0] SPK_CFG   = 3'h2;
  localparam logic [2:0] SPK_ANA   = 3'h3;
  localparam logic [2:0] SPK_COMM  = 3'h4;
  localparam int         LOCAL_BIT = 28;

  // register offsets
  localparam logic [11:0] A_CTRL    = 12'h000;
  localparam logic [11:0] A_SWTRIG  = 12'h004;
  localparam logic [11:0] A_CANCEL  = 12'h008;
  localparam logic [11:0] A_STALL   = 12'h00c;
  localparam logic [3:0]  A_CFG_PG  = 4'h1;
  localparam logic [3:0]  A_STAT_PG = 4'h2;
  localparam logic [1:0]  TDW_CFG   = 2'h0;
  localparam logic [1:0]  TDW_SRC   = 2'h1;
  localparam logic [1:0]  TDW_DST   = 2'h2;
  localparam logic [1:0]  TDW_NONE  = 2'h3;

  // field positions
  localparam int CT_FAIR  = 0;
  localparam int CF_EN    = 0;
  localparam int CF_PRIO  = 1;
  localparam int CF_NORR  = 4;
  localparam int CF_CHEN  = 5;
  localparam int CF_CHSRC = 8;
  localparam int CF_TD0   = 16;
  localparam int TD_LEN   = 0;
  localparam int TD_NEXT  = 16;
  localparam int TD_LAST  = 23;
  localparam int TD_INF   = 24;
  localparam int TD_SINC  = 25;
  localparam int TD_DINC  = 26;
  localparam int TD_IRQA  = 27;
  localparam int TD_IRQB  = 28;

  // reset values and writable masks
  localparam logic [31:0] CTRL_RST   = 32'h0000_0001;
  localparam logic [31:0] CTRL_MASK  = 32'h0000_0001;
  localparam logic [31:0] STALL_MASK = 32'h00ff_ffff;
  localparam logic [31:0] CFG_MASK   = 32'h007f_1f3f;
  localparam logic [31:0] TDC_MASK   = 32'h1fff_ffff;
  localparam logic [5:0]  SLOT_RST   = 6'h00;
  localparam logic [4:0]  RR_RST     = 5'h17;
  localparam logic [16:0] LEN_MAX    = 17'h10000;

  typedef enum logic [3:0] {
    OWN_NONE = 4'b0001,
    OWN_CPU  = 4'b0010,
    OWN_RD   = 4'b0100,
    OWN_WR   = 4'b1000
  } phd_own_t;

  typedef enum logic [2:0] {
    ENG_IDLE = 3'b001,
    ENG_RUN  = 3'b010,
    ENG_WB   = 3'b100
  } phd_eng_t;
endpackage

// *** core/phd_hub.sv ***
// peripheral hub: dma controller, channel arbiter, spoke router and apb registers
// Behaviour
// RULE1: two initiators, processor and dma, independent
// RULE2: eight parallel spoke bus segments
// RULE3: processor and dma concurrent on different spokes
// RULE4: dma read and write overlap across spokes
// RULE5: route access to spoke by address
// RULE6: shared pool of 128 descriptors
// RULE7: descriptors writable while running
// RULE8: eight priority levels, lower number wins
// RULE9: start by trigger, processor, or channel completion
// RULE10: two interrupt outputs per channel transfer
// RULE11: stall or cancel a channel
// RULE12: length infinite or 1 to 64K
// RULE13: chain next descriptor; descriptors may rewrite descriptors
// RULE14: processor wins shared spoke
// RULE15: processor can never starve dma
// RULE16: preemption only at transaction boundary
// RULE17: levels 0 and 1 bypass fairness
// RULE18: fairness shares for levels 2 to 7
// RULE19: round robin among equal-priority channels
// RULE20: per-channel opt-out of round robin
// RULE21: fairness off means pure priority
// RULE22: auto repeat via self-linked descriptor
// RULE23: reset idles channels, pointers at lowest
//
// The implementer's own choices: the register offsets and the APB slave port.
`timescale 1ns/1ps
module phd_hub #(
  parameter int BURST = phd_pkg::BURST_DEF
) (
  // clock and reset
  input  wire logic                               CORE_CLK,
  input  wire logic                               RESET,
  // apb register slave
  input  wire logic                               PSEL,
  input  wire logic                               PENABLE,
  input  wire logic                               PWRITE,
  input  wire logic [11:0]                        PADDR,
  input  wire logic [31:0]                        PWDATA,
  output logic      [31:0]                        PRDATA,
  output logic                                    PREADY,
  output logic                                    PSLVERR,
  // processor initiator
  input  wire logic                               CPU_REQ,
  input  wire logic                               CPU_WRITE,
  input  wire logic [phd_pkg::AW-1:0]             CPU_ADDR,
  input  wire logic [phd_pkg::DW-1:0]             CPU_WDATA,
  output logic                                    CPU_ACK,
  output logic      [phd_pkg::DW-1:0]             CPU_RDATA,
  // channel triggers and completion interrupts
  input  wire logic [phd_pkg::NCH-1:0]            DMA_TRIG,
  output logic      [phd_pkg::NCH-1:0]            TERM_A,
  output logic      [phd_pkg::NCH-1:0]            TERM_B,
  // spokes
  output logic      [phd_pkg::NSPK-1:0]           SPK_VALID,
  output logic      [phd_pkg::NSPK-1:0]           SPK_WRITE,
  output logic      [phd_pkg::NSPK*phd_pkg::AW-1:0] SPK_ADDR,
  output logic      [phd_pkg::NSPK*phd_pkg::DW-1:0] SPK_WDATA,
  input  wire logic [phd_pkg::NSPK*phd_pkg::DW-1:0] SPK_RDATA,
  input  wire logic [phd_pkg::NSPK-1:0]           SPK_READY
);
  import phd_pkg::*;

  function automatic logic [2:0] low_lvl(input logic [NLVL-1:0] a);
    logic [2:0] r;
    r = 3'h7;
    for (int i = NLVL - 1; i >= 0; i--)
      if (a[i]) r = 3'(i);
    return r;
  endfunction

  // favoured level per slot: lowest set bit i of the slot counter favours level i+2
  function automatic logic [3:0] fav_of(input logic [5:0] s);
    logic [3:0] r;
    r = 4'h0;
    for (int i = 5; i >= 0; i--)
      if (s[i]) r = {1'b1, 3'(i + 2)};
    return r;
  endfunction

  function automatic logic [4:0] pick(input logic [NCH-1:0] m, input logic [NCH-1:0] nr,
                                      input logic [4:0] p);
    logic [4:0] r;
    logic       f;
    int         k;
    r = 5'h0;
    f = 1'b0;
    k = 0;
    for (int i = 0; i < NCH; i++)
      if (!f && m[i] && nr[i])
      begin
        r = 5'(i);
        f = 1'b1;
      end
    for (int i = 1; i <= NCH; i++)
    begin
      k = (int'(p) + i) % NCH;
      if (!f && m[k])
      begin
        r = 5'(k);
        f = 1'b1;
      end
    end
    return r;
  endfunction

  logic [31:0]    ctrl_ff;
  logic [31:0]    stall_ff;
  logic [31:0]    td_cfg_ff [NTD];
  logic [31:0]    td_src_ff [NTD];
  logic [31:0]    td_dst_ff [NTD];
  logic [31:0]    ch_cfg [NCH];
  logic [6:0]     cur_td [NCH];
  logic [15:0]    cnt [NCH];
  logic [NCH-1:0] pend;
  logic [NCH-1:0] elig;
  logic [NCH-1:0] norr;
  logic [NCH-1:0] lvm [NLVL];
  logic [NLVL-1:0] lvl_any;
  logic [4:0]     rr_ff [NLVL];
  logic [5:0]     slot_ff;
  logic           cpu_busy_ff;
  logic [NSPK-1:0] g_cpu, g_rd, g_wr, f_cpu, f_rd, f_wr;

  // dma engine state
  phd_eng_t       eng_ff;
  logic [4:0]     ech_ff;
  logic [6:0]     etd_ff;
  logic [AW-1:0]  src_ff, dst_ff, rd_addr_ff, wr_addr_ff;
  logic [DW-1:0]  hold_ff, wr_data_ff;
  logic [7:0]     nb_ff, rd_left_ff, wr_left_ff;
  logic           rd_req_ff, rd_wait_ff, wr_req_ff, wr_busy_ff, hold_v_ff, kill_ff;
  logic           done_ev_ff;
  logic [4:0]     done_ch_ff;

  // register write port, shared by apb and dma writes into the local window
  logic        apb_setup, apb_we, wr_local, loc_we, reg_we;
  logic [11:0] reg_a;
  logic [31:0] reg_d;
  logic        we_ctrl, we_sw, we_cancel, we_stall, we_cfg, we_td;
  assign apb_setup = PSEL & ~PENABLE;
  assign apb_we    = PSEL & PENABLE & PWRITE & PREADY;
  assign wr_local  = (wr_addr_ff[SPK_LSB+:3] == SPK_CFG) & wr_addr_ff[LOCAL_BIT];
  // apb wins the port; a local dma write just waits a cycle
  assign loc_we    = wr_req_ff & wr_local & ~apb_we; // RULE13
  assign reg_we    = apb_we | loc_we;
  assign reg_a     = apb_we ? PADDR : wr_addr_ff[11:0];
  assign reg_d     = apb_we ? PWDATA : wr_data_ff;
  assign we_ctrl   = reg_we & (reg_a == A_CTRL);
  assign we_sw     = reg_we & (reg_a == A_SWTRIG);
  assign we_cancel = reg_we & (reg_a == A_CANCEL);
  assign we_stall  = reg_we & (reg_a == A_STALL);
  assign we_cfg    = reg_we & (reg_a[11:8] == A_CFG_PG) & (reg_a[7:2] < 6'(NCH));
  assign we_td     = reg_we & reg_a[11] & (reg_a[3:2] != TDW_NONE);

  // apb read decode
  logic        r_ok, r_chok;
  logic [4:0]  r_ch;
  logic [31:0] r_val;
  assign r_ch   = PADDR[6:2];
  assign r_chok = PADDR[7:2] < 6'(NCH);
  always_comb
  begin
    r_ok  = 1'b1;
    r_val = 32'h0;
    if (PADDR[11])
    begin
      unique case (PADDR[3:2])
        TDW_CFG:  r_val = td_cfg_ff[PADDR[10:4]];
        TDW_SRC:  r_val = td_src_ff[PADDR[10:4]];
        TDW_DST:  r_val = td_dst_ff[PADDR[10:4]];
        TDW_NONE: r_ok = 1'b0;
      endcase
    end
    else if (PADDR[11:8] == A_CFG_PG && r_chok)
      r_val = ch_cfg[r_ch];
    else if (PADDR[11:8] == A_STAT_PG && r_chok)
      r_val = {pend[r_ch], (eng_ff != ENG_IDLE) && (ech_ff == r_ch), 7'h0,
               cur_td[r_ch], cnt[r_ch]};
    else if (PADDR == A_CTRL)
      r_val = ctrl_ff;
    else if (PADDR == A_STALL)
      r_val = stall_ff;
    else if (PADDR != A_SWTRIG && PADDR != A_CANCEL)
      r_ok = 1'b0;
  end

  always_ff @(posedge CORE_CLK or posedge RESET)
    if (RESET)
    begin
      PREADY  <= 1'b0;
      PRDATA  <= 32'h0;
      PSLVERR <= 1'b0;
    end
    else
    begin
      PREADY  <= apb_setup;
      PSLVERR <= apb_setup & ~r_ok;
      if (apb_setup)
        PRDATA <= r_ok ? r_val : 32'h0;
    end

  // global control, stall mask and descriptor pool
  always_ff @(posedge CORE_CLK or posedge RESET)
    if (RESET)
    begin
      ctrl_ff  <= CTRL_RST;
      stall_ff <= 32'h0;
      for (int i = 0; i < NTD; i++)
      begin
        td_cfg_ff[i] <= 32'h0;
        td_src_ff[i] <= 32'h0;
        td_dst_ff[i] <= 32'h0;
      end
    end
    else
    begin
      if (we_ctrl)
        ctrl_ff <= reg_d & CTRL_MASK;
      if (we_stall)
        stall_ff <= reg_d & STALL_MASK; // RULE11
      if (we_td)
      begin
        // pool stays writable while channels run
        unique case (reg_a[3:2]) // RULE6 RULE7
          TDW_CFG: td_cfg_ff[reg_a[10:4]] <= reg_d & TDC_MASK;
          TDW_SRC: td_src_ff[reg_a[10:4]] <= reg_d;
          TDW_DST: td_dst_ff[reg_a[10:4]] <= reg_d;
          TDW_NONE: ;
        endcase
      end
    end

  // spoke router and per-spoke arbitration
  logic          cpu_want;
  logic [2:0]    cpu_spk, rd_spk, wr_spk;
  logic [DW-1:0] cpu_rd, dma_rd;
  assign cpu_want = CPU_REQ & ~cpu_busy_ff & ~CPU_ACK; // RULE1
  assign cpu_spk  = CPU_ADDR[SPK_LSB+:3]; // RULE5
  assign rd_spk   = rd_addr_ff[SPK_LSB+:3];
  assign wr_spk   = wr_addr_ff[SPK_LSB+:3];
  assign cpu_rd   = SPK_RDATA[cpu_spk*DW+:DW];
  assign dma_rd   = SPK_RDATA[rd_spk*DW+:DW];

  for (genvar s = 0; s < NSPK; s++) // RULE2 RULE3
  begin : g_spk
    phd_own_t      own_ff;
    logic          owed_ff, valid_ff, wrt_ff, hc, hr, hw, idle, dfirst, fin;
    logic [AW-1:0] addr_ff;
    logic [DW-1:0] wd_ff;
    assign hc       = cpu_want & (cpu_spk == 3'(s));
    assign hr       = rd_req_ff & (rd_spk == 3'(s));
    assign hw       = wr_req_ff & ~wr_local & (wr_spk == 3'(s));
    assign idle     = own_ff == OWN_NONE;
    // dma takes the next slot after having been passed over once
    assign dfirst   = owed_ff & (hr | hw); // RULE15
    assign g_cpu[s] = idle & hc & ~dfirst; // RULE14
    assign g_wr[s]  = idle & hw & ~g_cpu[s];
    assign g_rd[s]  = idle & hr & ~g_cpu[s] & ~hw;
    assign fin      = valid_ff & SPK_READY[s];
    assign f_cpu[s] = fin & (own_ff == OWN_CPU);
    assign f_rd[s]  = fin & (own_ff == OWN_RD);
    assign f_wr[s]  = fin & (own_ff == OWN_WR);
    assign SPK_VALID[s]          = valid_ff;
    assign SPK_WRITE[s]          = wrt_ff;
    assign SPK_ADDR[s*AW+:AW]    = addr_ff;
    assign SPK_WDATA[s*DW+:DW]   = wd_ff;
    always_ff @(posedge CORE_CLK or posedge RESET)
      if (RESET)
      begin
        own_ff   <= OWN_NONE;
        owed_ff  <= 1'b0;
        valid_ff <= 1'b0;
        wrt_ff   <= 1'b0;
        addr_ff  <= '0;
        wd_ff    <= '0;
      end
      else
      begin
        if (g_cpu[s])
        begin
          own_ff   <= OWN_CPU;
          valid_ff <= 1'b1;
          wrt_ff   <= CPU_WRITE;
          addr_ff  <= CPU_ADDR;
          wd_ff    <= CPU_WDATA;
        end
        else if (g_wr[s])
        begin
          own_ff   <= OWN_WR;
          valid_ff <= 1'b1;
          wrt_ff   <= 1'b1;
          addr_ff  <= wr_addr_ff;
          wd_ff    <= wr_data_ff;
        end
        else if (g_rd[s])
        begin
          own_ff   <= OWN_RD;
          valid_ff <= 1'b1;
          wrt_ff   <= 1'b0;
          addr_ff  <= rd_addr_ff;
        end
        else if (fin)
        begin
          own_ff   <= OWN_NONE;
          valid_ff <= 1'b0;
        end
        if (g_cpu[s] & (hr | hw))
          owed_ff <= 1'b1; // RULE15
        else if (g_wr[s] | g_rd[s])
          owed_ff <= 1'b0;
      end
  end

  always_ff @(posedge CORE_CLK or posedge RESET)
    if (RESET)
    begin
      cpu_busy_ff <= 1'b0;
      CPU_ACK     <= 1'b0;
      CPU_RDATA   <= '0;
    end
    else
    begin
      cpu_busy_ff <= (cpu_busy_ff | (|g_cpu)) & ~(|f_cpu);
      CPU_ACK     <= |f_cpu;
      if (|f_cpu)
        CPU_RDATA <= cpu_rd;
    end

  // channel arbiter
  logic       use_fav, fav_v, start;
  logic [2:0] top_l, fav_l, g_l;
  logic [4:0] g_ch;
  for (genvar l = 0; l < NLVL; l++)
  begin : g_lvl
    for (genvar c = 0; c < NCH; c++)
    begin : g_m
      assign lvm[l][c] = elig[c] & (ch_cfg[c][CF_PRIO+:3] == 3'(l)); // RULE8
    end
    assign lvl_any[l] = |lvm[l];
  end
  assign top_l          = low_lvl(lvl_any); // RULE8
  assign {fav_v, fav_l} = fav_of(slot_ff);
  // levels 0 and 1 always take precedence; fairness only shares among 2..7
  assign use_fav = ctrl_ff[CT_FAIR] & fav_v & (top_l >= 3'h2) & lvl_any[fav_l]; // RULE17 RULE18 RULE21
  assign g_l     = use_fav ? fav_l : top_l;
  assign g_ch    = pick(lvm[g_l], norr, rr_ff[g_l]); // RULE19 RULE20
  // arbitration only while idle, so a winner waits out the running burst
  assign start   = (eng_ff == ENG_IDLE) & (|elig); // RULE16

  always_ff @(posedge CORE_CLK or posedge RESET)
    if (RESET)
    begin
      slot_ff <= SLOT_RST;
      for (int l = 0; l < NLVL; l++)
        rr_ff[l] <= RR_RST; // RULE23
    end
    else if (start)
    begin
      if (top_l >= 3'h2)
        slot_ff <= slot_ff + 6'h1; // RULE18
      if (!norr[g_ch])
        rr_ff[g_l] <= g_ch; // RULE19
    end

  // burst setup and write-back values
  logic [6:0]  s_td;
  logic [31:0] s_tc, w_tc;
  logic [16:0] s_full, s_rem, w_full, w_new;
  logic [7:0]  s_nb;
  logic        w_done, wb_ok;
  assign s_td   = cur_td[g_ch];
  assign s_tc   = td_cfg_ff[s_td];
  assign s_full = (s_tc[TD_LEN+:16] == 16'h0) ? LEN_MAX : {1'b0, s_tc[TD_LEN+:16]}; // RULE12
  assign s_rem  = s_full - {1'b0, cnt[g_ch]};
  assign s_nb   = (s_tc[TD_INF] || s_rem >= 17'(BURST)) ? 8'(BURST) : s_rem[7:0];
  assign w_tc   = td_cfg_ff[etd_ff];
  assign w_full = (w_tc[TD_LEN+:16] == 16'h0) ? LEN_MAX : {1'b0, w_tc[TD_LEN+:16]};
  assign w_new  = {1'b0, cnt[ech_ff]} + {9'h0, nb_ff};
  assign w_done = ~w_tc[TD_INF] & (w_new == w_full); // RULE12
  assign wb_ok  = (eng_ff == ENG_WB) & ~kill_ff;

  // dma engine: one read in flight overlaps the previous word's write
  always_ff @(posedge CORE_CLK or posedge RESET)
    if (RESET)
    begin
      eng_ff <= ENG_IDLE;
      {ech_ff, etd_ff, nb_ff, rd_left_ff, wr_left_ff} <= '0;
      {src_ff, dst_ff, rd_addr_ff, wr_addr_ff, hold_ff, wr_data_ff} <= '0;
      {rd_req_ff, rd_wait_ff, wr_req_ff, wr_busy_ff, hold_v_ff, kill_ff} <= '0;
    end
    else
    begin
      unique case (eng_ff)
        ENG_IDLE:
          if (start)
          begin
            eng_ff     <= ENG_RUN;
            ech_ff     <= g_ch;
            etd_ff     <= s_td;
            nb_ff      <= s_nb;
            rd_left_ff <= s_nb;
            wr_left_ff <= s_nb;
            kill_ff    <= 1'b0;
            src_ff     <= td_src_ff[s_td] + (s_tc[TD_SINC] ? {16'h0, cnt[g_ch]} : 32'h0);
            dst_ff     <= td_dst_ff[s_td] + (s_tc[TD_DINC] ? {16'h0, cnt[g_ch]} : 32'h0);
          end
        ENG_RUN:
        begin
          if (rd_left_ff != 8'h0 && !rd_req_ff && !rd_wait_ff && !hold_v_ff)
          begin
            rd_req_ff  <= 1'b1;
            rd_addr_ff <= src_ff;
            rd_left_ff <= rd_left_ff - 8'h1;
            if (w_tc[TD_SINC])
              src_ff <= src_ff + 32'h1;
          end
          if (|g_rd)
          begin
            rd_req_ff  <= 1'b0;
            rd_wait_ff <= 1'b1;
          end
          if (|f_rd)
          begin
            rd_wait_ff <= 1'b0;
            hold_ff    <= dma_rd;
            hold_v_ff  <= 1'b1;
          end
          if (hold_v_ff && !wr_req_ff && !wr_busy_ff)
          begin
            wr_req_ff  <= 1'b1; // RULE4
            wr_addr_ff <= dst_ff;
            wr_data_ff <= hold_ff;
            hold_v_ff  <= 1'b0;
            if (w_tc[TD_DINC])
              dst_ff <= dst_ff + 32'h1;
          end
          if (|g_wr)
          begin
            wr_req_ff  <= 1'b0;
            wr_busy_ff <= 1'b1;
          end
          if (|f_wr)
            wr_busy_ff <= 1'b0;
          if (loc_we)
            wr_req_ff <= 1'b0;
          if ((|f_wr) || loc_we)
            wr_left_ff <= wr_left_ff - 8'h1;
          if (wr_left_ff == 8'h0)
            eng_ff <= ENG_WB;
          if (we_cancel && reg_d[ech_ff])
            kill_ff <= 1'b1; // RULE11
        end
        ENG_WB:
          eng_ff <= ENG_IDLE;
      endcase
    end

  // completion interrupts and the event that can trigger other channels
  always_ff @(posedge CORE_CLK or posedge RESET)
    if (RESET)
    begin
      TERM_A     <= '0;
      TERM_B     <= '0;
      done_ev_ff <= 1'b0;
      done_ch_ff <= 5'h0;
    end
    else
    begin
      TERM_A     <= '0;
      TERM_B     <= '0;
      done_ev_ff <= wb_ok & w_done;
      done_ch_ff <= ech_ff;
      if (wb_ok & w_done & w_tc[TD_IRQA])
        TERM_A[ech_ff] <= 1'b1; // RULE10
      if (wb_ok & w_done & w_tc[TD_IRQB])
        TERM_B[ech_ff] <= 1'b1; // RULE10
    end

  // per-channel state
  for (genvar c = 0; c < NCH; c++)
  begin : g_ch_st
    logic [31:0] cfg_ff;
    logic [6:0]  td_ff;
    logic [15:0] cnt_ff;
    logic        pend_ff, trig_q_ff, set, clr, can, cfgw, wbh;
    assign ch_cfg[c] = cfg_ff;
    assign cur_td[c] = td_ff;
    assign cnt[c]    = cnt_ff;
    assign pend[c]   = pend_ff;
    assign norr[c]   = cfg_ff[CF_NORR];
    assign elig[c]   = pend_ff & ~stall_ff[c] & cfg_ff[CF_EN]; // RULE11
    assign can       = we_cancel & reg_d[c];
    assign cfgw      = we_cfg & (reg_a[7:2] == 6'(c));
    assign wbh       = wb_ok & (ech_ff == 5'(c));
    assign set = (DMA_TRIG[c] & ~trig_q_ff) | (we_sw & reg_d[c]) // RULE9
               | (done_ev_ff & cfg_ff[CF_CHEN] & (done_ch_ff == cfg_ff[CF_CHSRC+:5]));
    assign clr = can | (wbh & w_done & w_tc[TD_LAST]);
    always_ff @(posedge CORE_CLK or posedge RESET)
      if (RESET)
      begin
        cfg_ff    <= 32'h0;
        td_ff     <= 7'h0;
        cnt_ff    <= 16'h0;
        pend_ff   <= 1'b0; // RULE23
        trig_q_ff <= 1'b0;
      end
      else
      begin
        trig_q_ff <= DMA_TRIG[c];
        // a new request in the clearing cycle is kept
        pend_ff <= cfg_ff[CF_EN] & (set | (pend_ff & ~clr));
        if (cfgw)
          cfg_ff <= reg_d & CFG_MASK;
        if (cfgw & ~pend_ff)
        begin
          td_ff  <= reg_d[CF_TD0+:7];
          cnt_ff <= 16'h0;
        end
        else if (can)
        begin
          td_ff  <= cfg_ff[CF_TD0+:7]; // RULE11
          cnt_ff <= 16'h0;
        end
        else if (wbh & w_done)
        begin
          // a self-linked descriptor simply starts over
          td_ff  <= w_tc[TD_LAST] ? cfg_ff[CF_TD0+:7] : w_tc[TD_NEXT+:7]; // RULE13 RULE22
          cnt_ff <= 16'h0;
        end
        else if (wbh)
          cnt_ff <= w_new[15:0];
      end
  end
endmodule

// *** sim/phd_hub_monitor.sv ***
// checker for the hub's apb, processor, spoke and completion ports
`timescale 1ns/1ps
module phd_hub_monitor (
  // clock and reset
  input wire logic         CORE_CLK,
  input wire logic         RESET,
  // watched ports
  input wire logic         PSEL,
  input wire logic         PENABLE,
  input wire logic         PREADY,
  input wire logic         PSLVERR,
  input wire logic         CPU_REQ,
  input wire logic         CPU_ACK,
  input wire logic [23:0]  TERM_A,
  input wire logic [7:0]   SPK_VALID,
  input wire logic [7:0]   SPK_READY,
  input wire logic [255:0] SPK_ADDR
);
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RESET);
  chk_apb_answer: assert property (PSEL && !PENABLE |=> PREADY)
    else $error("apb setup not answered next cycle");
  chk_ready_single: assert property (PREADY |=> !PREADY)
    else $error("apb ready longer than one cycle");
  chk_err_ready: assert property (PSLVERR |-> PREADY)
    else $error("apb error without ready");
  chk_ack_pulse: assert property (CPU_ACK |=> !CPU_ACK)
    else $error("processor ack longer than one cycle");
  chk_ack_cause: assert property (CPU_ACK |-> $past(CPU_REQ, 2))
    else $error("processor ack without request two cycles before");
  chk_valid_hold: assert property (SPK_VALID[0] && !SPK_READY[0] |=>
    SPK_VALID[0] && $stable(SPK_ADDR[31:0]))
    else $error("spoke 0 request dropped or changed before ready");
  chk_spoke_gap: assert property (SPK_VALID[4] && SPK_READY[4] |=> !SPK_VALID[4])
    else $error("spoke 4 missing idle cycle after completion");
  chk_route_sram: assert property (SPK_VALID[0] |-> SPK_ADDR[31:29] == 3'h0)
    else $error("spoke 0 carries foreign address");
  chk_route_comm: assert property (SPK_VALID[4] |-> SPK_ADDR[159:157] == 3'h4)
    else $error("spoke 4 carries foreign address");
  chk_term_pulse: assert property (|TERM_A |=> TERM_A == 24'h0)
    else $error("completion pulse longer than one cycle");
  cover property (PSLVERR);
  cover property (CPU_ACK);
  cover property (|TERM_A);
  cover property (SPK_VALID[0] && SPK_VALID[4]);
endmodule

bind phd_hub phd_hub_monitor u_mon (
  .CORE_CLK(CORE_CLK), .RESET(RESET), .PSEL(PSEL), .PENABLE(PENABLE), .PREADY(PREADY),
  .PSLVERR(PSLVERR), .CPU_REQ(CPU_REQ), .CPU_ACK(CPU_ACK), .TERM_A(TERM_A),
  .SPK_VALID(SPK_VALID), .SPK_READY(SPK_READY), .SPK_ADDR(SPK_ADDR)
);

// *** sim/phd_spoke_model.sv ***
// spoke slaves: ready at once or after one wait cycle, data from address
`timescale 1ns/1ps
module phd_spoke_model (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         slow,
  input  wire logic [7:0]   valid,
  input  wire logic [255:0] addr,
  output logic      [7:0]   ready,
  output logic      [255:0] rdata
);
  logic [7:0] wait_ff;
  always_ff @(posedge clk or posedge rst)
    if (rst)
      wait_ff <= 8'h00;
    else
      wait_ff <= valid & ~ready;
  assign ready = valid & (~{8{slow}} | wait_ff);
  // spokes not ready show inverted data so a stale word cannot pass
  always_comb
    for (int s = 0; s < 8; s++)
      rdata[s*32+:32] = ready[s] ? addr[s*32+:32] ^ 32'h5a5a_5a5a : ~addr[s*32+:32];
endmodule

// *** sim/phd_hub_tb_top.sv ***
// self-checking bench for the peripheral hub
`timescale 1ns/1ps
module phd_hub_tb_top;
  import phd_pkg::*;
  localparam logic [31:0] PAT = 32'h5a5a_5a5a;
  logic clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0, creq = 1'b0, slow = 1'b0;
  logic pready, pslverr, cack;
  logic [11:0]  paddr = 12'h000;
  logic [31:0]  pwdata = 32'h0, caddr = 32'h0, prdata, crdata, wa, wd;
  logic [23:0]  trig = 24'h0, term_a, term_b;
  logic [7:0]   sv, sw, sr;
  logic [255:0] sa, swd, srd;
  int           err_count = 0;
  int           tests_run = 0;

  phd_hub #(.BURST(2)) dut (
    .CORE_CLK(clk), .RESET(rst), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(paddr),
    .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .CPU_REQ(creq),
    .CPU_WRITE(1'b0), .CPU_ADDR(caddr), .CPU_WDATA(32'h0), .CPU_ACK(cack), .CPU_RDATA(crdata),
    .DMA_TRIG(trig), .TERM_A(term_a), .TERM_B(term_b), .SPK_VALID(sv), .SPK_WRITE(sw),
    .SPK_ADDR(sa), .SPK_WDATA(swd), .SPK_RDATA(srd), .SPK_READY(sr));
  phd_spoke_model far (.clk(clk), .rst(rst), .slow(slow), .valid(sv), .addr(sa),
    .ready(sr), .rdata(srd));

  initial forever #20 clk = ~clk;

  // last write seen on any spoke
  always @(posedge clk)
    for (int s = 0; s < 8; s++)
      if (sv[s] && sr[s] && sw[s])
      begin
        wa <= sa[s*32+:32];
        wd <= swd[s*32+:32];
      end

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    tests_run++;
    if (s !== e)
    begin
      err_count++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic hang(input logic ok);
    if (ok !== 1'b1)
    begin
      chk("bounded wait", 32'h1, 32'h0);
      give_verdict();
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    for (n = 0; n < 20 && pready !== 1'b1; n++) @(posedge clk);
    hang(pready);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask

  task automatic cpu_rd(input logic [31:0] a, output logic [31:0] r);
    int n;
    creq <= 1'b1;
    caddr <= a;
    for (n = 0; n < 60 && cack !== 1'b1; n++) @(posedge clk);
    hang(cack);
    r = crdata;
    creq <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wait_term(input int ch, input bit b);
    int n;
    for (n = 0; n < 400 && (b ? term_b[ch] : term_a[ch]) !== 1'b1; n++) @(posedge clk);
    hang(b ? term_b[ch] : term_a[ch]);
  endtask

  task automatic t_reset;
    logic [31:0] r;
    logic        e;
    apb(1'b0, A_CTRL, 32'h0, r, e);
    chk("ctrl reset", CTRL_RST, r);
    apb(1'b0, 12'h200, 32'h0, r, e);
    chk("chstat0 reset", 32'h0, r);
    apb(1'b0, A_STALL, 32'h0, r, e);
    chk("stall reset", 32'h0, r);
    $display("test reset done");
  endtask

  task automatic t_regs;
    logic [31:0] r;
    logic        e;
    apb(1'b1, 12'h804, 32'h0000_0100, r, e);
    apb(1'b0, 12'h804, 32'h0, r, e);
    chk("td source readback", 32'h0000_0100, r);
    apb(1'b1, 12'h80c, 32'hffff_ffff, r, e);
    chk("unmapped write error", 32'h1, {31'h0, e});
    apb(1'b0, 12'h80c, 32'h0, r, e);
    chk("unmapped read data", 32'h0, r);
    apb(1'b1, A_CTRL, 32'h0, r, e);
    apb(1'b0, A_CTRL, 32'h0, r, e);
    chk("fairness off", 32'h0, r);
    apb(1'b1, A_CTRL, 32'h1, r, e);
    $display("test registers done");
  endtask

  task automatic t_cpu;
    logic [31:0] r;
    cpu_rd(32'h8000_0010, r);
    chk("cpu read spoke 4", 32'h8000_0010 ^ PAT, r);
    slow <= 1'b1;
    cpu_rd(32'h0000_0020, r);
    chk("cpu read sram slow", 32'h0000_0020 ^ PAT, r);
    slow <= 1'b0;
    $display("test cpu done");
  endtask

  task automatic t_dma;
    logic [31:0] r;
    logic        e;
    // two elements, last, both increment, first interrupt
    apb(1'b1, 12'h800, 32'h0e80_0002, r, e);
    apb(1'b1, 12'h808, 32'h8000_0200, r, e);
    apb(1'b1, 12'h100, 32'h0000_0001, r, e);
    apb(1'b1, A_SWTRIG, 32'h1, r, e);
    wait_term(0, 1'b0);
    chk("dma last dest", 32'h8000_0201, wa);
    chk("dma last data", 32'h0000_0101 ^ PAT, wd);
    apb(1'b0, 12'h200, 32'h0, r, e);
    chk("ch0 idle after last", 32'h0, r & 32'hc000_0000);
    $display("test dma done");
  endtask

  task automatic t_trig;
    logic [31:0] r;
    logic        e;
    apb(1'b1, 12'h810, 32'h1080_0001, r, e);
    apb(1'b1, 12'h814, 32'h8000_0300, r, e);
    apb(1'b1, 12'h818, 32'h0000_0400, r, e);
    apb(1'b1, 12'h104, 32'h0001_0005, r, e);
    slow <= 1'b1;
    trig[1] <= 1'b1;
    wait_term(1, 1'b1);
    trig[1] <= 1'b0;
    slow <= 1'b0;
    chk("trig dest", 32'h0000_0400, wa);
    chk("trig data", 32'h8000_0300 ^ PAT, wd);
    $display("test trigger done");
  endtask

  initial
  begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_regs();
    t_cpu();
    t_dma();
    t_trig();
    give_verdict();
  end
endmodule
